//--- core/fswel_pkg.sv
package fswel_pkg;
  // stage counts
  localparam int NSTG = 8;
  localparam int NOVR = 4;
  // program tick timing
  localparam int CLK_MHZ = 100;
  localparam int TICK_US = 5000;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam int TDW = 20;
  // frequency values are in 0.01 Hz units
  localparam logic [16:0] HYST = 17'h00002;
  localparam logic [15:0] PICK_OVR_RST = 16'h13ec;
  localparam logic [15:0] PICK_UND_RST = 16'h1324;
  localparam logic [15:0] DLY_RST = 16'h0008;
  // history taps in ticks
  localparam int H20 = 4;
  localparam int H200 = 40;
  localparam int HIST_W = H200 * 16;
  // record memory
  localparam int REC_AW = 7;
  localparam int REC_DEPTH = 128;
  localparam int REC_W = 112;
  localparam logic [3:0] REC_LAST = 4'hb;
  // register byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_EN = 12'h004;
  localparam logic [11:0] OFF_FORCE = 12'h008;
  localparam logic [11:0] OFF_EVMASK = 12'h00c;
  localparam logic [11:0] OFF_UVTHR = 12'h010;
  localparam logic [11:0] OFF_STATUS = 12'h014;
  localparam logic [11:0] OFF_CNTCLR = 12'h018;
  localparam logic [11:0] OFF_CNT_ST = 12'h01c;
  localparam logic [11:0] OFF_CNT_TR = 12'h020;
  localparam logic [11:0] OFF_CNT_BL = 12'h024;
  localparam logic [11:0] OFF_RECSEL = 12'h028;
  localparam logic [11:0] OFF_REC0 = 12'h02c;
  localparam logic [11:0] OFF_REC1 = 12'h030;
  localparam logic [11:0] OFF_REC2 = 12'h034;
  localparam logic [11:0] OFF_REC3 = 12'h038;
  localparam logic [11:0] OFF_INUSE0 = 12'h040;
  localparam logic [11:0] OFF_INUSE1 = 12'h044;
  localparam logic [11:0] OFF_DLY = 12'h060;
  localparam logic [11:0] OFF_PICK = 12'h080;
  // stage state, gray along idle-start-trip
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_TRIP = 2'b11,
    ST_BLOCK = 2'b10
  } fswel_st_e;
  // logical node mode
  typedef enum logic [2:0] {
    LN_ON = 3'h0,
    LN_BLK = 3'h1,
    LN_TEST = 3'h2,
    LN_TBLK = 3'h3,
    LN_OFF = 3'h4
  } fswel_ln_e;
endpackage

//--- core/fswel_rec_mem.sv
`timescale 1ns/10ps
module fswel_rec_mem
  import fswel_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // write port
  input wire logic we,
  input wire logic [REC_AW-1:0] waddr,
  input wire logic [REC_W-1:0] wdata,
  // read port
  input wire logic [REC_AW-1:0] raddr,
  output logic [REC_W-1:0] rdata
);
  // storage has no reset; unwritten entries read unknown
  logic [REC_W-1:0] mem [REC_DEPTH];

  // write side
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // registered read, one cycle behind the address
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule

//--- core/fswel_stage.sv
`timescale 1ns/10ps
module fswel_stage
  import fswel_pkg::*;
#(
  parameter bit OVER = 1'b1
) (
  // clock, reset and program tick
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  // qualifiers
  input wire logic active,
  input wire logic blk,
  // measurement and settings
  input wire logic [15:0] freq,
  input wire logic [15:0] pick,
  input wire logic [15:0] delay,
  // status
  output logic start,
  output logic trip,
  output logic blocked,
  output logic [15:0] remain
);
  fswel_st_e st, next_st; // stage state
  logic [15:0] cnt, next_cnt; // elapsed ticks since start
  wire held = st != ST_IDLE;
  wire [16:0] f17 = {1'b0, freq};
  wire [16:0] p17 = {1'b0, pick};
  // threshold moves by the hysteresis once picked up
  wire [16:0] thr_o = held ? p17 - HYST : p17;
  wire [16:0] thr_u = held ? p17 + HYST : p17;
  wire pu = OVER ? (f17 > thr_o) : (f17 < thr_u);
  wire [15:0] elapsed = (st == ST_START) ? cnt + 16'h0001 : 16'h0000;

  // next state, evaluated once per program tick
  always_comb begin
    next_st = ST_IDLE;
    next_cnt = 16'h0000;
    if (active && pu) begin
      if (blk) begin
        next_st = ST_BLOCK;
      end else if (delay == 16'h0000) begin
        next_st = ST_TRIP;
      end else if (st == ST_TRIP || elapsed >= delay) begin
        next_st = ST_TRIP;
      end else begin
        next_st = ST_START;
        next_cnt = elapsed;
      end
    end
  end

  // state only moves on the tick, so block is sampled once per tick
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= ST_IDLE;
      cnt <= 16'h0000;
    end else if (tick) begin
      st <= next_st;
      cnt <= next_cnt;
    end
  end

  // output decode
  always_comb begin
    start = 1'b0;
    trip = 1'b0;
    blocked = 1'b0;
    case (st)
      ST_START: start = 1'b1;
      ST_TRIP: begin
        start = 1'b1;
        trip = 1'b1;
      end
      ST_BLOCK: blocked = 1'b1;
      default: ;
    endcase
  end

  // a delay lowered below the elapsed count shows zero, not a wrap
  assign remain = (st == ST_START && delay > cnt) ? delay - cnt : 16'h0000;

  inact_idle_a: assert property (
    @(posedge clk) disable iff (!rst_n) tick && !active |=> st == ST_IDLE)
    else $error("inactive stage left idle");
  blk_win_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    tick && active && pu && blk |=> blocked && !start)
    else $error("blocked pick-up did not block");
  zero_dly_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    tick && active && pu && !blk && delay == 16'h0000 |=> trip && start)
    else $error("zero delay did not trip at once");
  trip_rel_a: assert property (
    @(posedge clk) disable iff (!rst_n) tick && !pu |=> !trip && !start)
    else $error("release kept start or trip");
  // any frequency inside the 20 mHz band must keep a held stage up
  hyst_hold_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    tick && held && active && !blk &&
    (OVER ? (f17 + HYST > p17 && f17 <= p17) :
            (f17 < p17 + HYST && f17 >= p17)) |=> start)
    else $error("released inside hysteresis");
  no_early_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    tick && st == ST_IDLE && delay != 16'h0000 |=> !trip)
    else $error("tripped before delay");
endmodule

//--- core/fswel_top.sv
`timescale 1ns/10ps
module fswel_top
  import fswel_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // measurements, clock time and blocking matrix
  input wire logic [15:0] freq_ref0,
  input wire logic [15:0] freq_ref1,
  input wire logic [15:0] freq_ref2,
  input wire logic [15:0] volt_meas,
  input wire logic [NSTG-1:0] blk_in,
  input wire logic [31:0] time_stamp,
  // stage outputs
  output logic [NSTG-1:0] stage_start,
  output logic [NSTG-1:0] stage_trip,
  output logic [NSTG-1:0] stage_blocked,
  // event stream
  output logic ev_valid,
  output logic [2:0] ev_stage,
  output logic [2:0] ev_code,
  output logic [31:0] ev_time
);
  ////////////////////////////////////////////////////////////////////////////
  // program tick divider
  logic [TDW-1:0] div; // cycle count inside one tick
  wire tick = div == TDW'(TICK_CYCLES - 1);

  // one-cycle enable every 5 ms
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div <= '0;
    end else begin
      div <= tick ? '0 : div + TDW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register storage
  fswel_ln_e ln_mode; // node mode
  logic frc_perm; // forcing permitted
  logic grp; // active setting group
  logic [1:0] ref_sel; // frequency reference select
  logic [NSTG-1:0] stg_en; // static stage enables
  logic [2*NSTG-1:0] force_r; // two bits per stage
  logic [7:0] ev_mask; // one bit per event form
  logic [15:0] uv_thr; // 0.01 %Un units
  logic [NSTG-1:0] in_use [2]; // per group in-use flags
  logic [2:0] rs_stage; // record read stage
  logic [3:0] rs_entry; // record read entry
  logic [15:0] dly [NSTG]; // delay in ticks
  logic [15:0] pick [2*NSTG]; // pick-up per group and stage
  logic [31:0] cnt_st, cnt_tr, cnt_bl; // occurrence counters
  logic [REC_W-1:0] rec_rd; // record read data

  // write decode
  wire wr_en = psel & penable & pwrite;
  wire wr_ctrl = wr_en & (paddr == OFF_CTRL);
  wire wr_en_r = wr_en & (paddr == OFF_EN);
  wire wr_frc = wr_en & (paddr == OFF_FORCE);
  wire wr_mask = wr_en & (paddr == OFF_EVMASK);
  wire wr_uv = wr_en & (paddr == OFF_UVTHR);
  wire wr_rs = wr_en & (paddr == OFF_RECSEL);
  wire cnt_clr = wr_en & (paddr == OFF_CNTCLR) & pwdata[0];
  wire dly_hit = paddr[11:5] == OFF_DLY[11:5] && paddr[1:0] == 2'b00;
  wire pick_hit = paddr[11:6] == OFF_PICK[11:6] && paddr[1:0] == 2'b00;

  // control word: mode, forcing, group
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ln_mode <= LN_ON;
      frc_perm <= 1'b0;
      grp <= 1'b0;
      ref_sel <= 2'b00;
    end else if (wr_ctrl) begin
      ln_mode <= fswel_ln_e'(pwdata[2:0]);
      frc_perm <= pwdata[3];
      grp <= pwdata[4];
      ref_sel <= pwdata[6:5];
    end
  end

  // plain setting words
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stg_en <= '0;
      force_r <= '0;
      ev_mask <= 8'h3f;
      uv_thr <= 16'h0000;
    end else begin
      if (wr_en_r) stg_en <= pwdata[NSTG-1:0];
      if (wr_frc) force_r <= pwdata[2*NSTG-1:0];
      if (wr_mask) ev_mask <= {2'b00, pwdata[5:0]};
      if (wr_uv) uv_thr <= pwdata[15:0];
    end
  end

  // in-use flags and record selector
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      in_use[0] <= '0;
      in_use[1] <= '0;
      rs_stage <= 3'h0;
      rs_entry <= 4'h0;
    end else begin
      if (wr_en && paddr == OFF_INUSE0) in_use[0] <= pwdata[NSTG-1:0];
      if (wr_en && paddr == OFF_INUSE1) in_use[1] <= pwdata[NSTG-1:0];
      if (wr_rs) begin
        rs_stage <= pwdata[2:0];
        rs_entry <= pwdata[7:4];
      end
    end
  end

  // delay and pick-up tables, one loop per entry
  for (genvar i = 0; i < 2 * NSTG; i++) begin : g_pick
    localparam logic [15:0] PRST = (i % NSTG) < NOVR ?
                                   PICK_OVR_RST : PICK_UND_RST;
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        pick[i] <= PRST;
      end else if (wr_en && pick_hit && paddr[5:2] == 4'(i)) begin
        pick[i] <= pwdata[15:0];
      end
    end
    if (i < NSTG) begin : g_dly
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          dly[i] <= DLY_RST;
        end else if (wr_en && dly_hit && paddr[4:2] == 3'(i)) begin
          dly[i] <= pwdata[15:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux and apb answer
  logic [31:0] rd_mux; // selected read word
  logic rd_hit; // address is mapped

  // decode the read word; unmapped addresses answer with an error
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      OFF_CTRL: rd_mux = {25'h0, ref_sel, grp, frc_perm, ln_mode};
      OFF_EN: rd_mux = {24'h0, stg_en};
      OFF_FORCE: rd_mux = {16'h0, force_r};
      OFF_EVMASK: rd_mux = {24'h0, ev_mask};
      OFF_UVTHR: rd_mux = {16'h0, uv_thr};
      OFF_STATUS: rd_mux = {8'h0, stage_blocked, stage_trip, stage_start};
      OFF_CNTCLR: rd_mux = 32'h0000_0000;
      OFF_CNT_ST: rd_mux = cnt_st;
      OFF_CNT_TR: rd_mux = cnt_tr;
      OFF_CNT_BL: rd_mux = cnt_bl;
      OFF_RECSEL: rd_mux = {24'h0, rs_entry, 1'b0, rs_stage};
      OFF_REC0: rd_mux = rec_rd[111:80];
      OFF_REC1: rd_mux = rec_rd[79:48];
      OFF_REC2: rd_mux = rec_rd[47:16];
      OFF_REC3: rd_mux = {16'h0, rec_rd[15:0]};
      OFF_INUSE0: rd_mux = {24'h0, in_use[0]};
      OFF_INUSE1: rd_mux = {24'h0, in_use[1]};
      default: begin
        if (dly_hit) begin
          rd_mux = {16'h0, dly[paddr[4:2]]};
        end else if (pick_hit) begin
          rd_mux = {16'h0, pick[paddr[5:2]]};
        end else begin
          rd_hit = 1'b0;
        end
      end
    endcase
  end

  // answer is captured in the setup cycle, so no wait state is needed
  assign pready = 1'b1;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr <= ~rd_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // measurement path
  wire [15:0] f_sel = ref_sel == 2'b01 ? freq_ref1 :
                      ref_sel == 2'b10 ? freq_ref2 : freq_ref0;
  wire uv_blk = uv_thr != 16'h0000 && volt_meas < uv_thr;
  wire ln_off = ln_mode == LN_OFF;
  wire ln_blk = ln_mode == LN_BLK || ln_mode == LN_TBLK;
  logic [HIST_W-1:0] hist; // one frequency sample per tick
  wire [15:0] f_pre20 = hist[H20*16-1 -: 16];
  wire [15:0] f_pre200 = hist[HIST_W-1 -: 16];

  // sample history for the record entries
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hist <= '0;
    end else if (tick) begin
      hist <= {hist[HIST_W-17:0], f_sel};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stages, status forcing and event edges
  logic [NSTG-1:0] act, r_start, r_trip, r_blk; // raw stage status
  logic [15:0] remain [NSTG]; // trip time remaining per stage
  logic [2:0] pv [NSTG]; // previous reported status
  logic [63:0] new_ev; // eight event bits per stage
  logic [63:0] pend; // events waiting to be sent

  for (genvar s = 0; s < NSTG; s++) begin : g_stg
    wire [1:0] fc = force_r[2*s+1:2*s];
    wire fo = frc_perm & (fc != 2'b00);
    wire [2:0] cur = {stage_blocked[s], stage_trip[s], stage_start[s]};
    // qualifiers follow the active group at once
    assign act[s] = stg_en[s] & in_use[grp][s] & ~ln_off;
    fswel_stage #(
      .OVER(s < NOVR)
    ) u_stg (
      .clk(clk),
      .rst_n(rst_n),
      .tick(tick),
      .active(act[s]),
      .blk(blk_in[s] | ln_blk | (s >= NOVR && uv_blk)),
      .freq(f_sel),
      .pick(pick[{grp, 3'(s)}]),
      .delay(dly[s]),
      .start(r_start[s]),
      .trip(r_trip[s]),
      .blocked(r_blk[s]),
      .remain(remain[s])
    );
    // reported status, gated so a disabled stage stays silent
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        stage_start[s] <= 1'b0;
        stage_trip[s] <= 1'b0;
        stage_blocked[s] <= 1'b0;
        pv[s] <= 3'h0;
      end else begin
        stage_start[s] <= act[s] & (fo ? fc[0] ^ fc[1] : r_start[s]);
        stage_trip[s] <= act[s] & (fo ? fc == 2'b10 : r_trip[s]);
        stage_blocked[s] <= act[s] & (fo ? fc == 2'b11 : r_blk[s]);
        pv[s] <= cur;
      end
    end
    // even bit is the ON form, odd bit the OFF form
    assign new_ev[8*s+7:8*s] = {2'b00,
      ~cur[2] & pv[s][2], cur[2] & ~pv[s][2],
      ~cur[1] & pv[s][1], cur[1] & ~pv[s][1],
      ~cur[0] & pv[s][0], cur[0] & ~pv[s][0]};
  end

  ////////////////////////////////////////////////////////////////////////////
  // event scanner: one event per cycle, lowest stage first
  logic sel_any; // an event is pending
  logic [5:0] sel_idx; // stage and code of the chosen event

  // priority pick; last hit in the downward loop is the lowest
  always_comb begin
    sel_any = 1'b0;
    sel_idx = 6'h00;
    for (int i = 63; i >= 0; i--) begin
      if (pend[i]) begin
        sel_any = 1'b1;
        sel_idx = 6'(i);
      end
    end
  end

  wire [63:0] clr_ev = sel_any ? 64'h1 << sel_idx : 64'h0;
  wire sel_on = sel_any & ~sel_idx[0];
  wire [2:0] sel_stage = sel_idx[5:3];

  // a new edge in the clearing cycle survives
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend <= 64'h0;
    end else begin
      pend <= (pend & ~clr_ev) | new_ev;
    end
  end

  // event port, masked per form
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ev_valid <= 1'b0;
      ev_stage <= 3'h0;
      ev_code <= 3'h0;
      ev_time <= 32'h0000_0000;
    end else begin
      ev_valid <= sel_any & ev_mask[sel_idx[2:0]];
      ev_stage <= sel_stage;
      ev_code <= sel_idx[2:0];
      ev_time <= time_stamp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counters and operation record
  wire inc_st = sel_on & sel_idx[2:1] == 2'b00;
  wire inc_tr = sel_on & sel_idx[2:1] == 2'b01;
  wire inc_bl = sel_on & sel_idx[2:1] == 2'b10;

  // clear and count together leave a count of one
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_st <= 32'h0;
      cnt_tr <= 32'h0;
      cnt_bl <= 32'h0;
    end else begin
      cnt_st <= (cnt_clr ? 32'h0 : cnt_st) + {31'h0, inc_st};
      cnt_tr <= (cnt_clr ? 32'h0 : cnt_tr) + {31'h0, inc_tr};
      cnt_bl <= (cnt_clr ? 32'h0 : cnt_bl) + {31'h0, inc_bl};
    end
  end

  logic [3:0] wptr [NSTG]; // circular write pointer per stage

  for (genvar s = 0; s < NSTG; s++) begin : g_wp
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        wptr[s] <= 4'h0;
      end else if (sel_on && sel_stage == 3'(s)) begin
        wptr[s] <= wptr[s] == REC_LAST ? 4'h0 : wptr[s] + 4'h1;
      end
    end
  end

  wire [REC_W-1:0] rec_wd = {time_stamp, f_pre200, f_pre20, f_sel,
                             remain[sel_stage], 5'h00, sel_idx[2:0],
                             7'h00, grp};

  fswel_rec_mem u_rec (
    .clk(clk),
    .rst_n(rst_n),
    .we(sel_on),
    .waddr({sel_stage, wptr[sel_stage]}),
    .wdata(rec_wd),
    .raddr({rs_stage, rs_entry}),
    .rdata(rec_rd)
  );

  cnt_clr_a: assert property (
    @(posedge clk) disable iff (!rst_n) cnt_clr && !inc_st |=> cnt_st == 0)
    else $error("start counter not cleared");
  ev_mask_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    sel_any && !ev_mask[sel_idx[2:0]] |=> !ev_valid)
    else $error("masked event form was sent");
endmodule

//--- verif/fswel_freq_src.sv
`timescale 1ns/10ps
module fswel_freq_src
  import fswel_pkg::*;
#(
  parameter int TICK_CYCLES = 64
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // wanted conditions from the bench
  input wire logic [15:0] f_set,
  input wire logic [15:0] v_set,
  input wire logic [NSTG-1:0] blk_set,
  // tracking path and blocking matrix
  output logic [15:0] freq_ref0,
  output logic [15:0] freq_ref1,
  output logic [15:0] freq_ref2,
  output logic [15:0] volt_meas,
  output logic [NSTG-1:0] blk_in,
  output logic [31:0] time_stamp
);
  int cnt; // time base divider

  // references move only on their own time base, which keeps step with the
  // stage divider, so a new value lands on the edge of each program tick
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt <= 0;
      freq_ref0 <= 16'h1388;
      volt_meas <= 16'h2710;
    end else if (cnt == TICK_CYCLES - 1) begin
      cnt <= 0;
      freq_ref0 <= f_set;
      volt_meas <= v_set;
    end else begin
      cnt <= cnt + 1;
    end
  end

  // spare references stay nominal, so a wrong selection shows
  assign freq_ref1 = 16'h1388;
  assign freq_ref2 = 16'h1388;

  // block follows the bench one clock later; the bench raises it together with
  // the excursion, well before any delay runs out
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      blk_in <= 8'h00;
      time_stamp <= 32'h00000000;
    end else begin
      blk_in <= blk_set;
      time_stamp <= time_stamp + 32'h00000001;
    end
  end
endmodule

//--- verif/tb_frequency_stage_with_event_log.sv
`timescale 1ns/10ps
module tb_frequency_stage_with_event_log
  import fswel_pkg::*;
();
  localparam int TK = 64; // short program tick
  // expected {start, blocked} per node mode 0..4
  localparam logic [9:0] MODE_EXP = 10'b10_01_10_01_00;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic pready;
  logic pslverr;
  logic [31:0] prdata;
  logic [31:0] rd; // last read word
  logic rd_err; // last error flag
  logic [15:0] f_set = 16'h1388; // 50.00 Hz
  logic [15:0] v_set = 16'h2710;
  logic [NSTG-1:0] blk_set = 8'h00;
  logic [15:0] fr0, fr1, fr2, vm;
  logic [NSTG-1:0] blk, st, tr, bl;
  logic [31:0] ts, ev_time;
  logic ev_valid;
  logic [2:0] ev_stage, ev_code;
  logic [5:0] evq [$]; // events seen as {stage, code}
  int errors = 0;
  int samples_checked = 0;

  always #5 clk = ~clk;

  fswel_freq_src #(.TICK_CYCLES(TK)) i_src (.clk(clk), .rst_n(rst_n),
    .f_set(f_set), .v_set(v_set), .blk_set(blk_set), .freq_ref0(fr0),
    .freq_ref1(fr1), .freq_ref2(fr2), .volt_meas(vm), .blk_in(blk),
    .time_stamp(ts));

  fswel_top #(.TICK_CYCLES(TK)) i_dut (.clk(clk), .rst_n(rst_n),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .freq_ref0(fr0), .freq_ref1(fr1), .freq_ref2(fr2), .volt_meas(vm),
    .blk_in(blk), .time_stamp(ts), .stage_start(st), .stage_trip(tr),
    .stage_blocked(bl), .ev_valid(ev_valid), .ev_stage(ev_stage),
    .ev_code(ev_code), .ev_time(ev_time));

  // event monitor: one pulse is one event
  always @(posedge clk) begin
    if (ev_valid === 1'b1) begin
      evq.push_back({ev_stage, ev_code});
      check("ev_time", ev_time, ts - 32'h1);
    end
  end

  ////////////////////////////////////////////////////////////////////
  task automatic check(input string n, input logic [31:0] got,
                       input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
    end
  endtask

  task automatic wrap_up();
    if (errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input string n, input logic [11:0] a,
                       input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(n, rd, e);
  endtask

  task automatic ticks(input int n);
    repeat (n * TK) @(posedge clk);
  endtask

  // bounded wait for a stage start
  task automatic wait_start(input int s);
    int k = 0;
    while (st[s] !== 1'b1 && k < 6 * TK) begin
      @(posedge clk);
      k++;
    end
  endtask

  // compare and drop the gathered events, up to four
  task automatic evchk(input int n, input logic [23:0] e);
    check("ev_count", 32'(evq.size()), 32'(n));
    for (int i = 0; i < n && i < evq.size(); i++) begin
      check("ev", 32'(evq[i]), 32'(e[23-6*i -: 6]));
    end
    evq.delete();
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rdchk("ctrl", OFF_CTRL, 32'h0);
    rdchk("enable", OFF_EN, 32'h0);
    rdchk("force", OFF_FORCE, 32'h0);
    rdchk("inuse0", OFF_INUSE0, 32'h0);
    rdchk("uvthr", OFF_UVTHR, 32'h0);
    rdchk("pick_over", OFF_PICK, 32'h13ec);
    rdchk("pick_under", OFF_PICK + 12'h010, 32'h1324);
    apb(1'b0, 12'hffc, 32'h0);
    check("slverr", 32'(rd_err), 32'h1);
    // only stages 0 and 4 both enabled and in use
    wr(OFF_EN, 32'h15);
    wr(OFF_INUSE0, 32'h13);
    wr(OFF_DLY, 32'h2);
    wr(OFF_DLY + 12'h010, 32'h0);
    ticks(2);
    evq.delete();
    f_set <= 16'h13ed;
    wait_start(0);
    check("start", 32'(st), 32'h01);
    check("trip_early", 32'(tr[0]), 32'h0);
    ticks(1);
    check("trip_wait", 32'(tr[0]), 32'h0);
    ticks(1);
    check("trip", 32'(tr[0]), 32'h1);
    f_set <= 16'h13eb; // inside the release band
    ticks(3);
    check("held", 32'(st[0]), 32'h1);
    f_set <= 16'h13ea;
    ticks(3);
    check("release", 32'({st[0], tr[0]}), 32'h0);
    evchk(4, {6'h00, 6'h02, 6'h01, 6'h03});
    wr(OFF_RECSEL, 32'h10); // second entry of stage 0
    repeat (2) @(posedge clk);
    apb(1'b0, OFF_REC3, 32'h0);
    check("rec_code", 32'(rd[15:8]), 32'h2);
    // on forms only; counters ignore the mask
    wr(OFF_EVMASK, 32'h15);
    f_set <= 16'h13ed;
    ticks(5);
    f_set <= 16'h13ea;
    ticks(3);
    evchk(2, {6'h00, 6'h02, 12'h000});
    rdchk("cnt_start", OFF_CNT_ST, 32'h2);
    rdchk("cnt_trip", OFF_CNT_TR, 32'h2);
    wr(OFF_CNTCLR, 32'h1);
    rdchk("cnt_clr", OFF_CNT_ST, 32'h0);
    // low voltage holds off the under stage until threshold is zero
    v_set <= 16'h0032;
    wr(OFF_UVTHR, 32'h64);
    f_set <= 16'h1323;
    ticks(3);
    check("uv_block", 32'(st[4]), 32'h0);
    check("uv_blocked", 32'(bl[4]), 32'h1);
    wr(OFF_UVTHR, 32'h0);
    wait_start(4);
    check("instant", 32'(tr[4]), 32'h1);
    f_set <= 16'h1388;
    ticks(3);
    blk_set <= 8'h01;
    f_set <= 16'h13ed;
    ticks(3);
    check("blocked", 32'({st, bl}), 32'h0001);
    rdchk("cnt_blk", OFF_CNT_BL, 32'h2);
    blk_set <= 8'h00;
    for (int m = 0; m < 5; m++) begin
      wr(OFF_CTRL, 32'(m));
      ticks(3);
      check("mode", 32'({st[0], bl[0]}), 32'(MODE_EXP[9-2*m -: 2]));
    end
    wr(OFF_CTRL, 32'h20); // secondary reference is nominal
    ticks(3);
    check("ref_sel", 32'(st[0]), 32'h0);
    wr(OFF_CTRL, 32'h0);
    wr(OFF_PICK + 12'h020, 32'h1450);
    wr(OFF_INUSE1, 32'h01);
    ticks(3);
    wr(OFF_CTRL, 32'h10);
    ticks(3);
    check("group", 32'(st[0]), 32'h0);
    wr(OFF_CTRL, 32'h18);
    wr(OFF_FORCE, 32'h2);
    ticks(2);
    check("forced", 32'({st[0], tr[0]}), 32'h3);
    wrap_up();
  end

  // watchdog well beyond the planned ticks
  initial begin
    repeat (600 * TK) @(posedge clk);
    errors++;
    wrap_up();
  end
endmodule
